//--- hdl/ics_regs.sv
// Configuration, address, buffer and status registers with a slave address receiver
`timescale 1ns/1ps
`default_nettype none
module ics_regs (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic [7:0] regAddr,
    input wire logic [31:0] regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [31:0] regRdata,
    input wire logic sclIn,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOe,
    input wire ics_pkg::ics_events_s coreEvents,
    input wire ics_pkg::ics_errors_s coreErrors,
    input wire logic endOfTransferSignal,
    output logic dmaRequest,
    output logic lastTransfer,
    output logic eventIrq,
    output logic errorIrq,
    output logic irq,
    output logic [7:0] transferByte,
    output logic [5:0] peripheralClockMhz
);
    // Control word 1
    logic dmaFinalBlockFlag, dmaRequestEnable, bufferIrqEnable, eventIrqEnable, errorIrqEnable;
    // Own addresses
    logic ownAddressWidthSelect, secondAddressEnable;
    logic [9:0] ownAddr;
    logic [6:0] alternateSlaveAddress;
    // Status flags
    logic [6:0] errFlags;
    logic [4:0] evFlags;
    logic transmitEmptyFlag, receiveFullFlag;
    logic [3:0] irqStat, irqEn;
    // Link sampling and receiver
    logic [1:0] pinS1, pinS2, pinS3, pinF, pinFd;
    ics_pkg::ics_link_e state, next_state, after, next_after;
    logic [3:0] bitCnt;
    logic [7:0] shiftReg;

    // Register decode
    wire hitCtl1 = regAddr == ics_pkg::CTL1_OFS;
    wire hitAddr0 = regAddr == ics_pkg::ADDR0_OFS;
    wire hitAddr1 = regAddr == ics_pkg::ADDR1_OFS;
    wire hitData = regAddr == ics_pkg::DATA_OFS;
    wire hitStat = regAddr == ics_pkg::STAT0_OFS;
    wire hitIrqSt = regAddr == ics_pkg::IRQST_OFS;
    wire hitIrqClr = regAddr == ics_pkg::IRQCLR_OFS;
    wire hitIrqEn = regAddr == ics_pkg::IRQEN_OFS;
    wire wrData = regWrite & hitData;
    wire rdData = regRead & hitData;
    wire wrStat = regWrite & hitStat;
    wire rdStat = regRead & hitStat;

    // Filtered pin levels and their edges; bit 0 is the clock line, bit 1 the data line
    wire sclRise = pinF[0] & ~pinFd[0];
    wire sclFall = ~pinF[0] & pinFd[0];
    wire sclHigh = pinF[0] & pinFd[0];
    wire startCond = sclHigh & pinFd[1] & ~pinF[1];
    wire stopCond = sclHigh & ~pinFd[1] & pinF[1];
    wire stHead = state == ics_pkg::ST_HEAD;
    wire stLow10 = state == ics_pkg::ST_LOW10;
    wire stData = state == ics_pkg::ST_DATA;
    wire recv = stHead | stLow10 | stData;
    wire byteReady = recv & sclFall & (bitCnt == ics_pkg::BITS_PER_BYTE);

    // Address compare
    wire match7 = ~ownAddressWidthSelect & (shiftReg[7:1] == ownAddr[7:1]);
    wire matchAlt = secondAddressEnable & (shiftReg[7:1] == alternateSlaveAddress);
    wire head10 = ownAddressWidthSelect & (shiftReg[7:1] == {ics_pkg::HEADER10, ownAddr[9:8]});
    wire low10 = shiftReg == ownAddr[7:0];
    wire addrHit = byteReady & ((stHead & (match7 | matchAlt)) | (stLow10 & low10));
    wire ackNow = byteReady & ((stHead & head10) | stData) | addrHit;
    wire rxLoad = byteReady & stData;

    // Flag set and clear terms; a set in the cycle of a clear wins
    wire [6:0] errSet = coreErrors | {3'h0, rxLoad & receiveFullFlag, 3'h0};
    wire [6:0] errKeep = wrStat ? {regWdata[15:14], regWdata[12:8]} : 7'h7F;
    wire [4:0] evSet = {stopCond, coreEvents.header10Sent, coreEvents.byteDone, addrHit,
        coreEvents.startSent};
    wire [3:0] irqSet = {|errSet, stopCond, rxLoad, addrHit};
    wire [3:0] irqClr = (regWrite & hitIrqClr) ? regWdata[3:0] : 4'h0;
    wire [15:0] stat0 = {errFlags[6:5], 1'b0, errFlags[4:0], transmitEmptyFlag,
        receiveFullFlag, 1'b0, evFlags};

    // Read data selection; unmapped and reserved bits read as zero
    logic [31:0] next_rdata;
    always_comb begin
        next_rdata = ics_pkg::REG_RESET;
        if (hitCtl1) begin
            next_rdata[ics_pkg::CTL1_FINAL_BIT] = dmaFinalBlockFlag;
            next_rdata[ics_pkg::CTL1_DMAEN_BIT] = dmaRequestEnable;
            next_rdata[ics_pkg::CTL1_BUFFER_IRQ_ENABLE_BIT] = bufferIrqEnable;
            next_rdata[ics_pkg::CTL1_EVENT_IRQ_ENABLE_BIT] = eventIrqEnable;
            next_rdata[ics_pkg::CTL1_ERROR_IRQ_ENABLE_BIT] = errorIrqEnable;
            next_rdata[ics_pkg::CTL1_MHZ_LSB +: 6] = peripheralClockMhz;
        end else if (hitAddr0) begin
            next_rdata[ics_pkg::ADDR0_WIDE_BIT] = ownAddressWidthSelect;
            next_rdata[9:0] = ownAddr;
        end else if (hitAddr1) begin
            next_rdata[7:0] = {alternateSlaveAddress, secondAddressEnable};
        end else if (hitData) begin
            next_rdata[7:0] = transferByte;
        end else if (hitStat) begin
            next_rdata[15:0] = stat0;
        end else if (hitIrqSt) begin
            next_rdata[3:0] = irqStat;
        end else if (hitIrqEn) begin
            next_rdata[3:0] = irqEn;
        end
    end

    // Receiver sequencing; start restarts anywhere, stop always ends the frame
    always_comb begin
        next_state = state;
        next_after = after;
        if (startCond) begin
            next_state = ics_pkg::ST_HEAD;
        end else if (stopCond) begin
            next_state = ics_pkg::ST_IDLE;
        end else begin
            case (state)
                ics_pkg::ST_HEAD, ics_pkg::ST_LOW10, ics_pkg::ST_DATA: begin
                    if (byteReady) begin
                        next_state = ackNow ? ics_pkg::ST_ACK : ics_pkg::ST_SKIP;
                        if (stHead & head10) begin
                            next_after = ics_pkg::ST_LOW10;
                        end else if (stHead & shiftReg[0]) begin
                            next_after = ics_pkg::ST_SKIP; // Reads are served by the engine
                        end else begin
                            next_after = ics_pkg::ST_DATA;
                        end
                    end
                end
                ics_pkg::ST_ACK: begin
                    if (sclFall) begin
                        next_state = after;
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // Three-stage pin sampling; a level counts once stages two and three agree
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            pinS1 <= 2'h3;
            pinS2 <= 2'h3;
            pinS3 <= 2'h3;
            pinF <= 2'h3;
            pinFd <= 2'h3;
        end else begin
            pinS1 <= {sdaIn, sclIn};
            pinS2 <= pinS1;
            pinS3 <= pinS2;
            pinF <= (pinS2 & pinS3) | (pinF & (pinS2 ^ pinS3));
            pinFd <= pinF;
        end
    end

    // Receiver state, bit counter and shifter
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            state <= ics_pkg::ST_IDLE;
            after <= ics_pkg::ST_IDLE;
            bitCnt <= 4'h0;
            shiftReg <= ics_pkg::BYTE_RESET;
            sdaOut <= 1'b0;
            sdaOe <= 1'b0;
        end else begin
            state <= next_state;
            after <= next_after;
            sdaOut <= 1'b0;
            sdaOe <= next_state == ics_pkg::ST_ACK;
            if (startCond | (sclFall & (state == ics_pkg::ST_ACK))) begin
                bitCnt <= 4'h0;
            end else if (recv & sclRise & (bitCnt != ics_pkg::BITS_PER_BYTE)) begin
                bitCnt <= bitCnt + 4'h1;
                shiftReg <= {shiftReg[6:0], pinF[1]};
            end
        end
    end

    // Software-written configuration
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            {dmaFinalBlockFlag, dmaRequestEnable, bufferIrqEnable} <= 3'h0;
            {eventIrqEnable, errorIrqEnable} <= 2'h0;
            peripheralClockMhz <= 6'h00;
            {ownAddressWidthSelect, ownAddr} <= 11'h000;
            {alternateSlaveAddress, secondAddressEnable} <= 8'h00;
            irqEn <= 4'h0;
        end else if (regWrite) begin
            if (hitCtl1) begin
                dmaFinalBlockFlag <= regWdata[ics_pkg::CTL1_FINAL_BIT];
                dmaRequestEnable <= regWdata[ics_pkg::CTL1_DMAEN_BIT];
                bufferIrqEnable <= regWdata[ics_pkg::CTL1_BUFFER_IRQ_ENABLE_BIT];
                eventIrqEnable <= regWdata[ics_pkg::CTL1_EVENT_IRQ_ENABLE_BIT];
                errorIrqEnable <= regWdata[ics_pkg::CTL1_ERROR_IRQ_ENABLE_BIT];
                peripheralClockMhz <= regWdata[ics_pkg::CTL1_MHZ_LSB +: 6];
            end
            if (hitAddr0) begin
                ownAddressWidthSelect <= regWdata[ics_pkg::ADDR0_WIDE_BIT];
                ownAddr <= regWdata[9:0];
            end
            if (hitAddr1) begin
                alternateSlaveAddress <= regWdata[ics_pkg::ADDR_MID_LSB +: 7];
                secondAddressEnable <= regWdata[ics_pkg::ADDR_LOW_BIT];
            end
            if (hitIrqEn) begin
                irqEn <= regWdata[3:0];
            end
        end
    end

    // Byte buffer; a received byte wins over a software write in the same cycle
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            transferByte <= ics_pkg::BYTE_RESET;
        end else if (rxLoad) begin
            transferByte <= shiftReg;
        end else if (wrData) begin
            transferByte <= regWdata[7:0];
        end
    end

    // Status flags; event flags clear on a status read, error flags on a written 0
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            errFlags <= 7'h00;
            evFlags <= 5'h00;
            transmitEmptyFlag <= 1'b0;
            receiveFullFlag <= 1'b0;
            irqStat <= 4'h0;
        end else begin
            errFlags <= (errFlags & errKeep) | errSet;
            evFlags <= (evFlags & ~{5{rdStat}}) | evSet;
            transmitEmptyFlag <= (transmitEmptyFlag & ~wrData) | coreEvents.txTaken;
            receiveFullFlag <= (receiveFullFlag & ~rdData) | rxLoad;
            irqStat <= (irqStat & ~irqClr) | irqSet;
        end
    end

    // Registered outputs
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            regRdata <= ics_pkg::REG_RESET;
            {dmaRequest, lastTransfer, eventIrq, errorIrq, irq} <= 5'h00;
        end else begin
            regRdata <= regRead ? next_rdata : ics_pkg::REG_RESET;
            dmaRequest <= dmaRequestEnable & (transmitEmptyFlag | receiveFullFlag);
            lastTransfer <= endOfTransferSignal & dmaFinalBlockFlag;
            eventIrq <= eventIrqEnable & ((|evFlags) |
                (bufferIrqEnable & (transmitEmptyFlag | receiveFullFlag)));
            errorIrq <= errorIrqEnable & (|errFlags);
            irq <= |(irqStat & irqEn);
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);

    sequence headMatch7;
        byteReady && stHead && match7;
    endsequence
    sequence wrThenRd;
        (wrData && !rxLoad) ##1 (rdData && !rxLoad);
    endsequence

    dma_req_gate_a: assert property (dmaRequest |-> $past(dmaRequestEnable))
        else $error("DMA request without enable");
    last_xfer_a: assert property ((endOfTransferSignal && dmaFinalBlockFlag) |=> lastTransfer
        ##1 !lastTransfer) else $error("Last transfer mark wrong");
    buf_irq_gate_a: assert property (eventIrq && !$past(|evFlags) |->
        $past(bufferIrqEnable && eventIrqEnable)) else $error("Buffer irq without enables");
    event_irq_a: assert property (eventIrqEnable && (|evFlags) |=> eventIrq)
        else $error("Event irq missing");
    error_irq_a: assert property (errorIrqEnable && (|errFlags) |=> errorIrq)
        else $error("Error irq missing");
    err_set_wins_a: assert property ((|errSet) |=> (errFlags & $past(errSet)) == $past(errSet))
        else $error("Error flag set lost");
    err_write_one_a: assert property (wrStat && (&errKeep) && !(|errSet) |=>
        errFlags == $past(errFlags)) else $error("Writing one changed an error flag");
    addr7_ack_a: assert property (headMatch7 |=> sdaOe && evFlags[1] ##1 sdaOe)
        else $error("7-bit address not acknowledged");
    alt_addr_gate_a: assert property (addrHit && stHead && !match7 |-> secondAddressEnable)
        else $error("Second address answered while disabled");
    reserved_zero_a: assert property ($past(regRead) && $past(hitData) |->
        regRdata[31:8] == 24'h000000) else $error("Reserved data bits not zero");
    data_readback_a: assert property (wrThenRd |=> regRdata[7:0] == $past(regWdata[7:0], 2))
        else $error("Byte buffer readback wrong");
endmodule
`default_nettype wire

//--- hdl/ics_pkg.sv
// Shared constants, state codes and carriers of the two-wire controller register block
package ics_pkg;
    // Register byte offsets
    localparam logic [7:0] CTL1_OFS = 8'h04;
    localparam logic [7:0] ADDR0_OFS = 8'h08;
    localparam logic [7:0] ADDR1_OFS = 8'h0C;
    localparam logic [7:0] DATA_OFS = 8'h10;
    localparam logic [7:0] STAT0_OFS = 8'h14;
    localparam logic [7:0] IRQST_OFS = 8'h18;
    localparam logic [7:0] IRQCLR_OFS = 8'h1C;
    localparam logic [7:0] IRQEN_OFS = 8'h20;
    // Control word 1 field positions
    localparam int CTL1_FINAL_BIT = 12;
    localparam int CTL1_DMAEN_BIT = 11;
    localparam int CTL1_BUFFER_IRQ_ENABLE_BIT = 10;
    localparam int CTL1_EVENT_IRQ_ENABLE_BIT = 9;
    localparam int CTL1_ERROR_IRQ_ENABLE_BIT = 8;
    localparam int CTL1_MHZ_LSB = 0;
    // Own address field positions
    localparam int ADDR0_WIDE_BIT = 15;
    localparam int ADDR0_HI_LSB = 8;
    localparam int ADDR_MID_LSB = 1;
    localparam int ADDR_LOW_BIT = 0;
    // Status word 0 field positions
    localparam int STAT0_ERRHI_LSB = 14;
    localparam int STAT0_ERRLO_LSB = 8;
    localparam int STAT0_TXE_BIT = 7;
    localparam int STAT0_RXF_BIT = 6;
    localparam int STAT0_EV_LSB = 0;
    // Reset values
    localparam logic [31:0] REG_RESET = 32'h00000000;
    localparam logic [7:0] BYTE_RESET = 8'h00;
    // Byte bookkeeping and 10-bit header prefix
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [4:0] HEADER10 = 5'h1E;
    // Link receiver states
    typedef enum logic [5:0] {
        ST_IDLE = 6'h01,
        ST_HEAD = 6'h02,
        ST_LOW10 = 6'h04,
        ST_DATA = 6'h08,
        ST_ACK = 6'h10,
        ST_SKIP = 6'h20
    } ics_link_e;
    // Event pulses from the bus engine
    typedef struct packed {
        logic startSent;
        logic header10Sent;
        logic byteDone;
        logic txTaken;
    } ics_events_s;
    // Error pulses, ordered as the status word holds them
    typedef struct packed {
        logic alert;
        logic timeout;
        logic packet_check_mismatch_flag;
        logic overrun;
        logic nackErr;
        logic arbLoss;
        logic busErr;
    } ics_errors_s;
endpackage

//--- verif/ics_bus_master.sv
// Behavioural two-wire bus master that drives frames into the register block
`timescale 1ns/1ps
`default_nettype none
module ics_bus_master (
    input wire logic sdaOe,
    input wire logic sdaOut,
    output logic scl,
    output wire logic sda
);
    logic sdaDrv;
    // Open-drain data line with pull-up; the block only pulls low when it drives a 0
    assign sda = sdaDrv & (~sdaOe | sdaOut);
    // Bus idles high; the clock stands still between frames
    initial begin
        scl = 1'b1;
        sdaDrv = 1'b1;
    end
    // Data falls while clock high; odd offset keeps link edges off the system edges
    task automatic start();
        #7;
        sdaDrv = 1'b0;
        #100 scl = 1'b0;
        #100;
    endtask
    // Data rises while clock high, then a long idle so the receiver sees the stop
    task automatic stop();
        sdaDrv = 1'b0;
        #100 scl = 1'b1;
        #100 sdaDrv = 1'b1;
        #200;
    endtask
    // Eight bits MSB first at 200 ns per clock, then release and sample the acknowledge
    task automatic send(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            sdaDrv = b[i];
            #100 scl = 1'b1;
            #100 scl = 1'b0;
        end
        #50 sdaDrv = 1'b1;
        #100 scl = 1'b1;
        #50 ack = ~sda;
        #50 scl = 1'b0;
        #50;
    endtask
endmodule
`default_nettype wire

//--- verif/testbench.sv
// Self-checking bench for the two-wire controller register block
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic clk_sys = 1'b0;
    logic reset_n = 1'b0;
    logic [7:0] regAddr = 8'h00;
    logic [31:0] regWdata = 32'h00000000;
    logic regWrite = 1'b0;
    logic regRead = 1'b0;
    logic [31:0] regRdata;
    wire logic scl;
    wire logic sda;
    logic sdaOut;
    logic sdaOe;
    ics_pkg::ics_events_s coreEvents = '0;
    ics_pkg::ics_errors_s coreErrors = '0;
    logic endOfTransferSignal = 1'b0;
    logic dmaRequest, lastTransfer, eventIrq, errorIrq, irq;
    logic [7:0] transferByte;
    logic [5:0] peripheralClockMhz;
    logic [31:0] rdata, v;
    logic ack;
    logic [9:0] a10;
    logic [6:0] a7;
    int err_total = 0;
    int n_compared = 0;
    int lastSeen = 0;
    logic [31:0] mask [4] = '{32'h00001F3F, 32'h000083FF, 32'h000000FF, 32'h000000FF};

    // 40 MHz clock, well above the fast-mode-plus floor
    always #12.5 clk_sys = ~clk_sys;

    ics_regs ics_regs_i (.clk_sys(clk_sys), .reset_n(reset_n), .regAddr(regAddr),
        .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
        .sclIn(scl), .sdaIn(sda), .sdaOut(sdaOut), .sdaOe(sdaOe), .coreEvents(coreEvents),
        .coreErrors(coreErrors), .endOfTransferSignal(endOfTransferSignal),
        .dmaRequest(dmaRequest), .lastTransfer(lastTransfer), .eventIrq(eventIrq),
        .errorIrq(errorIrq), .irq(irq), .transferByte(transferByte),
        .peripheralClockMhz(peripheralClockMhz));

    ics_bus_master ics_bus_master_i (.sdaOe(sdaOe), .sdaOut(sdaOut), .scl(scl), .sda(sda));

    // Counts last-transfer cycles so a stretched or missing pulse shows up
    always @(posedge clk_sys) if (lastTransfer === 1'b1) lastSeen++;

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
            err_total++;
        end
    endtask
    // Whole-word accesses only
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        regAddr <= a;
        regWdata <= d;
        regWrite <= 1'b1;
        @(posedge clk_sys);
        regWrite <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a);
        @(posedge clk_sys);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge clk_sys);
        regRead <= 1'b0;
        #1 rdata = regRdata;
    endtask
    // Write then read back with no gap between the strobes
    task automatic wrrd(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        regAddr <= a;
        regWdata <= d;
        regWrite <= 1'b1;
        @(posedge clk_sys);
        regWrite <= 1'b0;
        regRead <= 1'b1;
        @(posedge clk_sys);
        regRead <= 1'b0;
        #1 rdata = regRdata;
    endtask
    // Status bit of error i; bit 13 is reserved, so the two top errors sit one higher
    function automatic logic [31:0] errBit(input int i);
        return 32'h00000001 << (8 + i + (i >= 5 ? 1 : 0));
    endfunction
    // Status bit raised by the engine event on struct bit i
    function automatic logic [31:0] evBit(input int i);
        return i == 3 ? 32'h00000001 : (i == 2 ? 32'h00000008 : 32'h00000004);
    endfunction
    // One-cycle pulses from the engine, then time for flags and outputs to settle
    task automatic pulse(input logic [3:0] ev, input logic [6:0] er, input logic end_of_transfer_signal);
        @(posedge clk_sys);
        coreEvents <= ev;
        coreErrors <= er;
        endOfTransferSignal <= end_of_transfer_signal;
        @(posedge clk_sys);
        coreEvents <= '0;
        coreErrors <= '0;
        endOfTransferSignal <= 1'b0;
        repeat (3) @(posedge clk_sys);
        #1;
    endtask
    // Address byte and one data byte; the second acknowledge tells whether it matched
    task automatic frame(input logic [7:0] b0, input logic [7:0] b1, input logic exp);
        ics_bus_master_i.start();
        ics_bus_master_i.send(b0, ack);
        ics_bus_master_i.send(b1, ack);
        ics_bus_master_i.stop();
        chk(ack, exp);
    endtask
    task automatic end_of_test();
        if (err_total == 0 && n_compared > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    // Hang guard, far beyond the few tens of microseconds the sequence needs
    initial begin
        #2000000;
        err_total++;
        end_of_test();
    end

    // Main sequence
    initial begin
        void'($urandom(32'h0326));
        repeat (20) @(posedge clk_sys);
        reset_n <= 1'b1;
        // Reset values, unmapped places and reserved bits
        for (int a = 0; a <= 36; a += 4) begin
            rd(8'(a));
            chk(rdata, 32'h00000000);
        end
        // Random readback; clock field kept within its legal codes
        for (int k = 0; k < 16; k++) begin
            v = $urandom;
            v[5:0] = 6'($urandom_range(2, 60));
            wrrd(8'(4 + 4 * (k % 4)), v);
            chk(rdata, v & mask[k % 4]);
            if (k % 4 == 0) chk(32'(peripheralClockMhz), 32'(v[5:0]));
            if (k % 4 == 3) chk(32'(transferByte), 32'(v[7:0]));
        end
        wr(8'h04, 32'h00000000);
        // DMA requests follow the enable
        pulse(4'h1, 7'h00, 1'b0);
        chk(32'(dmaRequest), 32'h0);
        wr(8'h04, 32'h00000800);
        repeat (3) @(posedge clk_sys);
        #1 chk(32'(dmaRequest), 32'h1);
        // Last-transfer marking only with the final-block flag
        wr(8'h04, 32'h00001000);
        lastSeen = 0;
        pulse(4'h0, 7'h00, 1'b1);
        chk(32'(lastSeen), 32'h1);
        wr(8'h04, 32'h00000000);
        pulse(4'h0, 7'h00, 1'b1);
        chk(32'(lastSeen), 32'h1);
        // Buffer empty needs both enables
        wr(8'h04, 32'h00000200);
        pulse(4'h1, 7'h00, 1'b0);
        chk(32'(eventIrq), 32'h0);
        wr(8'h04, 32'h00000600);
        repeat (3) @(posedge clk_sys);
        #1 chk(32'(eventIrq), 32'h1);
        wr(8'h10, 32'h00000000);
        repeat (3) @(posedge clk_sys);
        #1 chk(32'(eventIrq), 32'h0);
        // Start, 10-bit header and byte-done events each raise the event interrupt until status is read
        for (int i = 1; i <= 3; i++) begin
            pulse(4'(1 << i), 7'h00, 1'b0);
            chk(32'(eventIrq), 32'h1);
            rd(8'h14);
            chk(rdata & 32'h0000001F, evBit(i));
            repeat (3) @(posedge clk_sys);
            #1 chk(32'(eventIrq), 32'h0);
        end
        // Every error flag: raise, keep on writing 1, clear on writing 0
        wr(8'h04, 32'h00000100);
        for (int i = 0; i < 7; i++) begin
            pulse(4'h0, 7'(1 << i), 1'b0);
            chk(32'(errorIrq), 32'h1);
            wr(8'h14, 32'h0000FFFF);
            rd(8'h14);
            chk(rdata & 32'h0000FF00, errBit(i));
            wr(8'h14, 32'h00000000);
            rd(8'h14);
            chk(rdata & 32'h0000FF00, 32'h0);
            repeat (3) @(posedge clk_sys);
            #1 chk(32'(errorIrq), 32'h0);
        end
        // Link traffic with the summary interrupt
        wr(8'h1C, 32'h0000000F);
        wr(8'h04, 32'h00000000);
        // Second address left random by the readback loop; switch it off first
        wr(8'h0C, 32'h00000000);
        a7 = 7'($urandom_range(8, 119));
        v = 32'($urandom_range(0, 255));
        wr(8'h08, {24'h0, a7, 1'b0});
        frame({a7, 1'b0}, v[7:0], 1'b1);
        chk(32'(transferByte), v & 32'hFF);
        chk(32'(irq), 32'h0);
        wr(8'h20, 32'h0000000F);
        repeat (2) @(posedge clk_sys);
        #1 chk(32'(irq), 32'h1);
        rd(8'h18);
        chk(rdata, 32'h00000007);
        rd(8'h10);
        chk(rdata, v & 32'hFF);
        wr(8'h1C, 32'h0000000F);
        repeat (2) @(posedge clk_sys);
        #1 chk(32'(irq), 32'h0);
        frame({a7 ^ 7'h01, 1'b0}, 8'h3C, 1'b0);
        // Read direction: address answered, following bytes left to the engine
        frame({a7, 1'b1}, 8'hA5, 1'b0);
        // Second address answered only while enabled
        wr(8'h0C, {24'h0, a7 ^ 7'h10, 1'b0});
        frame({a7 ^ 7'h10, 1'b0}, 8'h5A, 1'b0);
        wr(8'h0C, {24'h0, a7 ^ 7'h10, 1'b1});
        frame({a7 ^ 7'h10, 1'b0}, 8'hC3, 1'b1);
        // Ten-bit own address: header then low byte
        a10 = 10'($urandom_range(0, 1023));
        wr(8'h08, {16'h0, 1'b1, 5'h00, a10});
        frame({5'h1E, a10[9:8], 1'b0}, a10[7:0], 1'b1);
        frame({5'h1E, a10[9:8], 1'b0}, a10[7:0] ^ 8'h01, 1'b0);
        end_of_test();
    end
endmodule
`default_nettype wire
